// >>> src/jtep_pkg.sv
// Shared constants and types for the test and emulation pin logic
package jtep_pkg;
	// Tap controller states, standard sixteen-state sequence
	typedef enum logic [3:0] {
		JTEP_RESET = 4'h0,
		JTEP_IDLE = 4'h1,
		JTEP_SEL_DR = 4'h2,
		JTEP_CAP_DR = 4'h3,
		JTEP_SH_DR = 4'h4,
		JTEP_EX1_DR = 4'h5,
		JTEP_PA_DR = 4'h6,
		JTEP_EX2_DR = 4'h7,
		JTEP_UP_DR = 4'h8,
		JTEP_SEL_IR = 4'h9,
		JTEP_CAP_IR = 4'hA,
		JTEP_SH_IR = 4'hB,
		JTEP_EX1_IR = 4'hC,
		JTEP_PA_IR = 4'hD,
		JTEP_EX2_IR = 4'hE,
		JTEP_UP_IR = 4'hF
	} jtep_state_t;
	localparam int JTEP_IR_W = 4;
	localparam int JTEP_DR_W = 8;
	localparam logic [3:0] JTEP_IR_RST = 4'h1;
	localparam logic [3:0] JTEP_IR_CAPT = 4'h1;
	// Instruction codes
	localparam logic [3:0] JTEP_OP_BYPASS = 4'hF;
	localparam logic [3:0] JTEP_OP_DATA = 4'h2;
	localparam logic [3:0] JTEP_OP_EMUCTL = 4'h3;
	// Emulation control data register field positions
	localparam int JTEP_EMU_A_OE = 0;
	localparam int JTEP_EMU_B_OE = 1;
	localparam int JTEP_EMU_A_VAL = 2;
	localparam int JTEP_EMU_B_VAL = 3;
	localparam logic [7:0] JTEP_DR_RST = 8'h00;
	localparam int JTEP_FIFO_W = 8;
	localparam int JTEP_FIFO_D = 16;
	// Host link clock divider: half period in core cycles
	localparam logic [3:0] JTEP_DIV_HALF = 4'h8;
endpackage

// >>> src/jtep_link_if.sv
// Link between the scan tester end and the device test pins
`timescale 1ns/10ps
interface jtep_link_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst;
	logic tdo_o;
	logic tdo_oe;
	logic emu_a_dev_o;
	logic emu_a_dev_oe;
	logic emu_a_host_o;
	logic emu_a_host_oe;
	logic emu_b_dev_o;
	logic emu_b_dev_oe;
	logic emu_b_host_o;
	logic emu_b_host_oe;
	logic pull_en;
	// Resolved pin levels; pulled high when nobody drives
	wire tdo = tdo_oe ? tdo_o : 1'b1;
	wire emulation_pin_a = emu_a_dev_oe ? emu_a_dev_o :
		(emu_a_host_oe ? emu_a_host_o : 1'b1);
	wire emulation_pin_b_outputs_off = emu_b_dev_oe ? emu_b_dev_o :
		(emu_b_host_oe ? emu_b_host_o : 1'b1);
	modport device (
		input tck, tms, tdi, trst, emulation_pin_a,
		input emulation_pin_b_outputs_off,
		output tdo_o, tdo_oe, emu_a_dev_o, emu_a_dev_oe,
		output emu_b_dev_o, emu_b_dev_oe, pull_en
	);
	modport host (
		output tck, tms, tdi, trst, emu_a_host_o, emu_a_host_oe,
		output emu_b_host_o, emu_b_host_oe,
		input tdo, emulation_pin_a, emulation_pin_b_outputs_off
	);
endinterface

// >>> src/jtep_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module jtep_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] cnt, next_cnt;
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic push, pop;
	// Honest full and empty from the occupancy count
	assign in_ready = (cnt != (AW+1)'(D));
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Pointer and count update
	always_comb begin
		next_wp = push ? AW'(wp + 1'b1) : wp;
		next_rp = pop ? AW'(rp + 1'b1) : rp;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
	// Storage has no reset; only written words are read
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end
endmodule

// >>> src/jtep_device.sv
// Device end: tap controller, emulation pins and outputs-off logic
`timescale 1ns/10ps
module jtep_device
	import jtep_pkg::*;
(
	// Core clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Link
	jtep_link_if.device link,
	// Software pullup control
	input wire logic pullup_enable,
	// Core side data stream from the scan data register
	output logic scan_valid,
	input wire logic scan_ready,
	output logic [JTEP_FIFO_W-1:0] scan_data,
	// Core side status
	output logic scan_mode,
	output logic all_outputs_off,
	output logic emu_a_level,
	output logic emu_b_level
);
	// ------------------------------------------------------------
	// Tap domain (link clock)
	// ------------------------------------------------------------
	jtep_state_t st, next_st;
	logic [JTEP_IR_W-1:0] ir_sh, next_ir_sh, ir, next_ir;
	logic [JTEP_DR_W-1:0] dr_sh, next_dr_sh, emu_ctl, next_emu_ctl;
	logic byp, next_byp;
	logic tdo_q, tdo_en;
	logic wtog, next_wtog;
	logic [JTEP_DR_W-1:0] wdata, next_wdata;
	logic tap_rst;
	// Test reset low holds the tap in reset; pin is asynchronous
	assign tap_rst = sys_rst || !link.trst;

	// Standard sixteen-state transition
	function automatic jtep_state_t tap_next(jtep_state_t s, logic m);
		case (s)
			JTEP_RESET: tap_next = m ? JTEP_RESET : JTEP_IDLE;
			JTEP_IDLE: tap_next = m ? JTEP_SEL_DR : JTEP_IDLE;
			JTEP_SEL_DR: tap_next = m ? JTEP_SEL_IR : JTEP_CAP_DR;
			JTEP_CAP_DR: tap_next = m ? JTEP_EX1_DR : JTEP_SH_DR;
			JTEP_SH_DR: tap_next = m ? JTEP_EX1_DR : JTEP_SH_DR;
			JTEP_EX1_DR: tap_next = m ? JTEP_UP_DR : JTEP_PA_DR;
			JTEP_PA_DR: tap_next = m ? JTEP_EX2_DR : JTEP_PA_DR;
			JTEP_EX2_DR: tap_next = m ? JTEP_UP_DR : JTEP_SH_DR;
			JTEP_UP_DR: tap_next = m ? JTEP_SEL_DR : JTEP_IDLE;
			JTEP_SEL_IR: tap_next = m ? JTEP_RESET : JTEP_CAP_IR;
			JTEP_CAP_IR: tap_next = m ? JTEP_EX1_IR : JTEP_SH_IR;
			JTEP_SH_IR: tap_next = m ? JTEP_EX1_IR : JTEP_SH_IR;
			JTEP_EX1_IR: tap_next = m ? JTEP_UP_IR : JTEP_PA_IR;
			JTEP_PA_IR: tap_next = m ? JTEP_EX2_IR : JTEP_PA_IR;
			JTEP_EX2_IR: tap_next = m ? JTEP_UP_IR : JTEP_SH_IR;
			JTEP_UP_IR: tap_next = m ? JTEP_SEL_DR : JTEP_IDLE;
			default: tap_next = JTEP_RESET;
		endcase
	endfunction

	// Next-state and register shifting on rising test clock
	always_comb begin
		next_st = tap_next(st, link.tms);
		next_ir_sh = ir_sh;
		next_ir = ir;
		next_dr_sh = dr_sh;
		next_emu_ctl = emu_ctl;
		next_byp = byp;
		next_wtog = wtog;
		next_wdata = wdata;
		case (st)
			JTEP_RESET: next_ir = JTEP_IR_RST;
			JTEP_CAP_IR: next_ir_sh = JTEP_IR_CAPT;
			JTEP_SH_IR: next_ir_sh = {link.tdi, ir_sh[JTEP_IR_W-1:1]};
			JTEP_UP_IR: next_ir = ir_sh;
			JTEP_CAP_DR: begin
				next_byp = 1'b0;
				next_dr_sh = (ir == JTEP_OP_EMUCTL) ? emu_ctl : JTEP_DR_RST;
			end
			JTEP_SH_DR: begin
				next_byp = link.tdi;
				next_dr_sh = {link.tdi, dr_sh[JTEP_DR_W-1:1]};
			end
			JTEP_UP_DR: begin
				// Scan sets direction and level of both emulation pins
				if (ir == JTEP_OP_EMUCTL) begin
					next_emu_ctl = dr_sh;
				end
				if (ir == JTEP_OP_DATA) begin
					next_wdata = dr_sh;
					next_wtog = !wtog;
				end
			end
			default: ;
		endcase
	end
	always_ff @(posedge link.tck or posedge tap_rst) begin
		if (tap_rst) begin
			st <= JTEP_RESET;
			ir_sh <= '0;
			ir <= JTEP_IR_RST;
			dr_sh <= JTEP_DR_RST;
			emu_ctl <= JTEP_DR_RST;
			byp <= 1'b0;
			wtog <= 1'b0;
			wdata <= JTEP_DR_RST;
		end else begin
			st <= next_st;
			ir_sh <= next_ir_sh;
			ir <= next_ir;
			dr_sh <= next_dr_sh;
			emu_ctl <= next_emu_ctl;
			byp <= next_byp;
			wtog <= next_wtog;
			wdata <= next_wdata;
		end
	end

	// Output bit and enable change on the falling test clock
	always_ff @(negedge link.tck or posedge tap_rst) begin
		if (tap_rst) begin
			tdo_q <= 1'b0;
			tdo_en <= 1'b0;
		end else begin
			tdo_q <= (st == JTEP_SH_IR) ? ir_sh[0] :
				(ir == JTEP_OP_BYPASS ? byp : dr_sh[0]);
			tdo_en <= (st == JTEP_SH_IR) || (st == JTEP_SH_DR);
		end
	end
	assign link.tdo_o = tdo_q;
	assign link.tdo_oe = tdo_en && link.trst;

	// Emulation pins driven only under scan control
	assign link.emu_a_dev_oe = link.trst && emu_ctl[JTEP_EMU_A_OE];
	assign link.emu_a_dev_o = emu_ctl[JTEP_EMU_A_VAL];
	assign link.emu_b_dev_oe = link.trst && emu_ctl[JTEP_EMU_B_OE];
	assign link.emu_b_dev_o = emu_ctl[JTEP_EMU_B_VAL];
	assign link.pull_en = pullup_enable;

	// ------------------------------------------------------------
	// Core domain crossings
	// ------------------------------------------------------------
	logic [1:0] s_trst, s_ea, s_eb, s_tog;
	logic tog_seen, next_tog_seen;
	logic push;
	logic fifo_in_ready;
	// Two flops on each asynchronous level and the word toggle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_trst <= '0;
			s_ea <= 2'h3;
			s_eb <= 2'h3;
			s_tog <= '0;
			tog_seen <= 1'b0;
		end else begin
			s_trst <= {s_trst[0], link.trst};
			s_ea <= {s_ea[0], link.emulation_pin_a};
			s_eb <= {s_eb[0], link.emulation_pin_b_outputs_off};
			s_tog <= {s_tog[0], wtog};
			tog_seen <= next_tog_seen;
		end
	end
	// Word is stable in wdata since its toggle was synchronised
	assign push = (s_tog[1] != tog_seen);
	always_comb begin
		next_tog_seen = tog_seen;
		if (push && fifo_in_ready) begin
			next_tog_seen = s_tog[1];
		end
	end

	assign scan_mode = s_trst[1];
	assign emu_a_level = s_ea[1];
	assign emu_b_level = s_eb[1];
	// Outputs-off: reset low, pin a high, pin b low; test use only
	assign all_outputs_off = !s_trst[1] && s_ea[1] && !s_eb[1];

	jtep_fifo #(.W(JTEP_FIFO_W), .D(JTEP_FIFO_D)) u_fifo (
		.clk(core_clk),
		.rst(sys_rst),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(wdata),
		.out_valid(scan_valid),
		.out_ready(scan_ready),
		.out_data(scan_data)
	);
endmodule

// >>> src/jtep_host.sv
// Tester end: drives test clock by division and shifts words in
`timescale 1ns/10ps
module jtep_host
	import jtep_pkg::*;
(
	// Core clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Link
	jtep_link_if.host link,
	// Mode control
	input wire logic scan_enable,
	input wire logic off_request,
	// Words to scan into the data register
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [JTEP_DR_W-1:0] cmd_data,
	// Captured output
	output logic [JTEP_DR_W-1:0] cap_data,
	output logic busy
);
	typedef enum logic [2:0] {
		JTEP_H_IDLE = 3'h0,
		JTEP_H_IR = 3'h1,
		JTEP_H_DR = 3'h2
	} jtep_hst_t;
	jtep_hst_t hs, next_hs;
	logic [3:0] div, next_div;
	logic tck, next_tck;
	logic [5:0] step, next_step;
	logic [JTEP_DR_W-1:0] sh, next_sh, cap, next_cap;
	logic tms, next_tms, tdi, next_tdi;
	logic [1:0] s_tdo;
	logic rise;
	logic fall;
	// rise and fall mark the core cycles where tck goes high or low
	assign rise = (div == JTEP_DIV_HALF - 1'b1) && !tck;
	assign fall = (div == JTEP_DIV_HALF - 1'b1) && tck;
	// Commands run even with test reset low, so the device must ignore them
	assign cmd_ready = (hs == JTEP_H_IDLE);
	assign busy = (hs != JTEP_H_IDLE);

	// Sequence: reset->idle, load data opcode, then shift 8 bits
	// Each step is one TCK rise; tms/tdi change on tck falling
	always_comb begin
		next_div = (div == JTEP_DIV_HALF - 1'b1) ? 4'h0 : div + 4'h1;
		next_tck = (div == JTEP_DIV_HALF - 1'b1) ? !tck : tck;
		next_hs = hs;
		next_step = step;
		next_sh = sh;
		next_cap = cap;
		next_tms = tms;
		next_tdi = tdi;
		case (hs)
			JTEP_H_IDLE: begin
				next_tms = 1'b0;
				if (cmd_valid && cmd_ready) begin
					next_hs = JTEP_H_IR;
					next_sh = cmd_data;
					next_step = '0;
				end
			end
			JTEP_H_IR, JTEP_H_DR: if (fall) begin
				next_step = step + 6'h01;
				// Lead idle rise, IR scan of the opcode, then DR scan
				case (step)
					6'h00: next_tms = 1'b0;
					6'h01, 6'h02: next_tms = 1'b1;
					6'h03, 6'h04: next_tms = 1'b0;
					6'h05, 6'h06, 6'h07: begin
						next_tdi = JTEP_OP_DATA[step[1:0] - 2'h1];
					end
					6'h08: begin
						next_tdi = JTEP_OP_DATA[3];
						next_tms = 1'b1;
					end
					6'h09, 6'h0A: next_tms = 1'b1;
					6'h0B: begin
						next_tms = 1'b0;
						next_hs = JTEP_H_DR;
					end
					6'h0C: next_tms = 1'b0;
					6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13: begin
						next_tdi = sh[0];
						next_sh = {1'b0, sh[JTEP_DR_W-1:1]};
					end
					6'h14: begin
						next_tdi = sh[0];
						next_tms = 1'b1;
					end
					6'h15: next_tms = 1'b1;
					6'h16: next_tms = 1'b0;
					default: begin
						next_tms = 1'b0;
						next_hs = JTEP_H_IDLE;
					end
				endcase
			end
			default: next_hs = JTEP_H_IDLE;
		endcase
		// Sample at the eight shift rises; tdo settled since the fall
		if (rise && hs == JTEP_H_DR && step >= 6'h0E && step <= 6'h15) begin
			next_cap = {s_tdo[1], cap[JTEP_DR_W-1:1]};
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hs <= JTEP_H_IDLE;
			div <= '0;
			tck <= 1'b0;
			step <= '0;
			sh <= '0;
			cap <= '0;
			tms <= 1'b0;
			tdi <= 1'b0;
			s_tdo <= '0;
			cap_data <= '0;
		end else begin
			hs <= next_hs;
			div <= next_div;
			tck <= next_tck;
			step <= next_step;
			sh <= next_sh;
			cap <= next_cap;
			tms <= next_tms;
			tdi <= next_tdi;
			s_tdo <= {s_tdo[0], link.tdo};
			cap_data <= (next_hs == JTEP_H_IDLE && hs == JTEP_H_DR) ?
				next_cap : cap_data;
		end
	end

	// Test reset high only when scanning; off request uses pins
	assign link.tck = tck;
	assign link.tms = tms;
	assign link.tdi = tdi;
	assign link.trst = scan_enable;
	assign link.emu_a_host_oe = !scan_enable && off_request;
	assign link.emu_a_host_o = 1'b1;
	assign link.emu_b_host_oe = !scan_enable && off_request;
	assign link.emu_b_host_o = 1'b0;
endmodule

// >>> dv/jtep_link_props.sv
// Checker for the scan link between the tester end and the device end
`timescale 1ns/10ps
module jtep_link_props
	import jtep_pkg::*;
(
	// Scan clock and control
	input wire logic tck,
	input wire logic tms,
	input wire logic trst,
	// Device drivers
	input wire logic tdo_o,
	input wire logic tdo_oe,
	input wire logic emu_a_dev_oe,
	input wire logic emu_b_dev_oe,
	// Resolved pins
	input wire logic tdo,
	input wire logic emulation_pin_a,
	input wire logic emulation_pin_b_outputs_off
);
	// ------------------------------------------------------------
	// Reference tap sequence
	// ------------------------------------------------------------
	jtep_state_t st;
	jtep_state_t next_st;
	logic rise_o;
	logic in_shift;
	default clocking dcb @(posedge tck); endclocking
	default disable iff (!trst);
	// Next tap state from mode select
	always_comb begin
		case (st)
			JTEP_RESET: next_st = tms ? JTEP_RESET : JTEP_IDLE;
			JTEP_IDLE: next_st = tms ? JTEP_SEL_DR : JTEP_IDLE;
			JTEP_SEL_DR: next_st = tms ? JTEP_SEL_IR : JTEP_CAP_DR;
			JTEP_CAP_DR: next_st = tms ? JTEP_EX1_DR : JTEP_SH_DR;
			JTEP_SH_DR: next_st = tms ? JTEP_EX1_DR : JTEP_SH_DR;
			JTEP_EX1_DR: next_st = tms ? JTEP_UP_DR : JTEP_PA_DR;
			JTEP_PA_DR: next_st = tms ? JTEP_EX2_DR : JTEP_PA_DR;
			JTEP_EX2_DR: next_st = tms ? JTEP_UP_DR : JTEP_SH_DR;
			JTEP_SEL_IR: next_st = tms ? JTEP_RESET : JTEP_CAP_IR;
			JTEP_CAP_IR: next_st = tms ? JTEP_EX1_IR : JTEP_SH_IR;
			JTEP_SH_IR: next_st = tms ? JTEP_EX1_IR : JTEP_SH_IR;
			JTEP_EX1_IR: next_st = tms ? JTEP_UP_IR : JTEP_PA_IR;
			JTEP_PA_IR: next_st = tms ? JTEP_EX2_IR : JTEP_PA_IR;
			JTEP_EX2_IR: next_st = tms ? JTEP_UP_IR : JTEP_SH_IR;
			default: next_st = tms ? JTEP_SEL_DR : JTEP_IDLE;
		endcase
	end
	// Test reset low pins the model in reset, like the device
	always_ff @(posedge tck or negedge trst) begin
		if (!trst) st <= JTEP_RESET;
		else st <= next_st;
	end
	// Output held at the rise; it may only move at the next fall
	always_ff @(posedge tck or negedge trst) begin
		if (!trst) rise_o <= 1'b0;
		else rise_o <= tdo_o;
	end
	assign in_shift = (st == JTEP_SH_DR) || (st == JTEP_SH_IR);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_enter_ir;
		st == JTEP_CAP_IR ##1 st == JTEP_SH_IR;
	endsequence
	property p_tdo_neg;
		@(negedge tck) tdo_o == rise_o;
	endproperty
	a_tdo_neg: assert property (p_tdo_neg) else $error("tdo moved");
	property p_oe_on;
		in_shift |-> tdo_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("tdo idle");
	property p_oe_off;
		!in_shift |-> !tdo_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("tdo driven");
	property p_float;
		!tdo_oe |-> tdo;
	endproperty
	a_float: assert property (p_float) else $error("tdo not high");
	property p_scan_off;
		disable iff (1'b0) !trst |-> !tdo_oe && !emu_a_dev_oe && !emu_b_dev_oe;
	endproperty
	a_scan_off: assert property (p_scan_off) else $error("pin driven");
	property p_ir_capt;
		s_enter_ir |-> tdo_o == JTEP_IR_CAPT[0] ##1
			(st != JTEP_SH_IR || tdo_o == JTEP_IR_CAPT[1]);
	endproperty
	a_ir_capt: assert property (p_ir_capt) else $error("ir bits");
	property p_emu_dir;
		st != JTEP_UP_DR && $past(st) != JTEP_UP_DR |->
			$stable(emu_a_dev_oe) && $stable(emu_b_dev_oe);
	endproperty
	a_emu_dir: assert property (p_emu_dir) else $error("emu dir");
	property p_off_pins;
		disable iff (1'b0) !trst && !emulation_pin_b_outputs_off |->
			emulation_pin_a;
	endproperty
	a_off_pins: assert property (p_off_pins) else $error("pin a low");
endmodule

// >>> dv/test_jtag_test_emulation_pins.sv
// Bench joining tester end and device end over the scan link
`timescale 1ns/10ps
module test_jtag_test_emulation_pins;
	import jtep_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic core_clk;
	logic sys_rst;
	logic pullup_enable;
	logic scan_ready;
	logic scan_enable;
	logic off_request;
	logic cmd_valid;
	logic [7:0] cmd_data;
	logic scan_valid;
	logic [7:0] scan_data;
	logic scan_mode;
	logic all_outputs_off;
	logic emu_a_level;
	logic emu_b_level;
	logic cmd_ready;
	logic [7:0] cap_data;
	logic busy;
	int fails = 0;
	int checks = 0;
	jtep_link_if link ();
	jtep_device jtep_device_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.link(link), .pullup_enable(pullup_enable),
		.scan_valid(scan_valid), .scan_ready(scan_ready),
		.scan_data(scan_data), .scan_mode(scan_mode),
		.all_outputs_off(all_outputs_off), .emu_a_level(emu_a_level),
		.emu_b_level(emu_b_level));
	jtep_host jtep_host_inst (.core_clk(core_clk), .sys_rst(sys_rst),
		.link(link), .scan_enable(scan_enable), .off_request(off_request),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
		.cap_data(cap_data), .busy(busy));
	jtep_link_props jtep_link_props_inst (.tck(link.tck), .tms(link.tms),
		.trst(link.trst), .tdo_o(link.tdo_o), .tdo_oe(link.tdo_oe),
		.emu_a_dev_oe(link.emu_a_dev_oe), .emu_b_dev_oe(link.emu_b_dev_oe),
		.tdo(link.tdo), .emulation_pin_a(link.emulation_pin_a),
		.emulation_pin_b_outputs_off(link.emulation_pin_b_outputs_off));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic end_of_test;
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic hang;
		fails++;
		$display("ERROR %0t: wait ran out", $time);
		end_of_test;
	endtask
	// Settled sampling point is the falling core edge
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Hold the command until taken, then wait for the scan to finish
	task automatic send(input logic [7:0] word);
		int n;
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_data <= word;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 500);
		cmd_valid <= 1'b0;
		if (n == 500) hang;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (busy !== 1'b0 && n < 1000);
		if (n == 1000) hang;
	endtask
	// Pop one word from the device stream
	task automatic pop(input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (scan_valid !== 1'b1 && n < 1000);
		if (n == 1000) hang;
		chk(scan_data, exp);
		@(posedge core_clk);
		scan_ready <= 1'b1;
		@(posedge core_clk);
		scan_ready <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		sys_rst = 1'b1;
		pullup_enable = 1'b1;
		scan_ready = 1'b0;
		scan_enable = 1'b0;
		off_request = 1'b0;
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		wt(8);
		chk(link.pull_en, 1'b1);
		chk(scan_mode, 1'b0);
		chk(all_outputs_off, 1'b0);
		chk({emu_a_level, emu_b_level}, 8'h03);
		@(posedge core_clk);
		pullup_enable <= 1'b0;
		off_request <= 1'b1;
		wt(8);
		chk(link.pull_en, 1'b0);
		chk(all_outputs_off, 1'b1);
		chk({emu_a_level, emu_b_level}, 8'h02);
		// Scan traffic with test reset low must not reach the core
		send(8'h5A);
		wt(8);
		chk(scan_valid, 1'b0);
		chk(cap_data, 8'hFF);
		@(posedge core_clk);
		scan_enable <= 1'b1;
		wt(8);
		chk(scan_mode, 1'b1);
		chk(all_outputs_off, 1'b0);
		// Fill the buffer with the core stalled, then drain it
		for (int i = 0; i < JTEP_FIFO_D; i++) begin
			send(8'(i * 17));
		end
		wt(8);
		for (int i = 0; i < JTEP_FIFO_D; i++) begin
			pop(8'(i * 17));
		end
		wt(8);
		chk(scan_valid, 1'b0);
		chk(cap_data, JTEP_DR_RST);
		end_of_test;
	end
endmodule
